// ==== rtl/hub_port_defs.vh ====
`ifndef HUB_PORT_DEFS_VH
`define HUB_PORT_DEFS_VH

////////////////////////////////////////////////////////////////////////////
// Clock and timing
`define CLK_MHZ            125
`define T_SUSP_DLY_US      2000
`define SUSP_DLY_CYC       20'd250000
`define T_DDIS_NS          2500
// 2.5 us rounded up to whole cycles
`define DDIS_CYC           20'd313
`define T_DIS_HOLD_US      4000
`define DIS_HOLD_CYC       20'd500000
`define TMR_W              20

////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define REG_CTRL           8'h00
`define REG_CMD            8'h04
`define REG_STATUS         8'h08
`define REG_CHANGE         8'h0c

// Control fields
`define CTRL_CFG_LSB       0
`define CTRL_CFG_MSB       7
`define CTRL_RWU_BIT       8
`define CTRL_RESET         9'h000

// Command bits, write one to act
`define CMD_CLR_POWER      0
`define CMD_SET_POWER      1
`define CMD_CLR_ENABLE     2
`define CMD_SET_ENABLE     3

// Status fields
`define STS_PST_LSB        0
`define STS_IST_LSB        4
`define STS_CONN_BIT       8
`define STS_HST_BIT        9
`define STS_WAKE_BIT       10
`define STS_SE0_LSB        16

// Change bits, write one to clear
`define CHG_CONN_BIT       0
`define CHG_ENA_BIT        1
`define CHG_OC_BIT         2

////////////////////////////////////////////////////////////////////////////
// Downstream port states
`define PST_NOTCFG         3'h0
`define PST_PWROFF         3'h1
`define PST_DISCON         3'h2
`define PST_DISABLED       3'h3
`define PST_ENABLED        3'h4

// Internal port states
`define IST_INACTIVE       2'h0
`define IST_SUSP_DLY       2'h1
`define IST_FSUS           2'h2
`define IST_GRESUME        2'h3

`endif

// ==== rtl/hub_port_fsm.v ====
// Function
// RL1: Receiver suspend starts a timed suspend delay, then full suspend.
// RL2: Full suspend moves to generate-resume on a resume condition.
// RL3: Resume: any suspend change, or wakeup armed and any change bit.
// RL4: In generate-resume, emit start-of-packet emulation toward the repeater.
// RL5: Configuration zero holds the port Not Configured, driving SE0 only.
// RL6: Outside Not Configured, power clear, loss or over-current powers off.
// RL7: Accepting a nonzero configuration powers the port off from any state.
// RL8: Over-current on another port that sags this supply powers the port off.
// RL9: Self-powered configured hub losing external power powers ports off.
// RL10: Bus-powered hub ignores new external power, powers off on its loss.
// RL11: Powered-off disables differential and single-ended transceivers.
// RL12: Set-port-power moves a Powered-off port to Disconnected.
// RL13: Disconnect timeout or restart end moves the port to Disconnected.
// RL14: Disconnected disables differential path and only detects connection.
// RL15: Disconnected timer held on SE0/SE1, runs otherwise, bounded expiry.
// RL16: Suspended with wakeup, connect activity requests clocks and is timed.
// RL17: Without wakeup, Disconnected line changes are ignored while suspended.
// RL18: Disconnected connect timer expiry enters Disabled.
// RL19: Clear-port-enable or port error while enabled enters Disabled.
// RL20: Disabled blocks both directions but times every received SE0.
// RL21: Disabled entry drops HS terminations and delays disconnect detection.
// RL22: Ties rank Not Configured, Powered-off, Disconnected, then Disabled.
`timescale 1ns/1ps
`include "hub_port_defs.vh"

module hub_port_fsm #(
    parameter [`TMR_W-1:0] SUSP_DLY_CYC = `SUSP_DLY_CYC,
    parameter [`TMR_W-1:0] DIS_HOLD_CYC = `DIS_HOLD_CYC,
    parameter              ROOT_SE0     = 1
) (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // Port line pins and power pins
    input  wire        dp_i,
    input  wire        dm_i,
    input  wire        pwr_fault_i,
    input  wire        oc_i,
    input  wire        oc_other_i,
    input  wire        ext_pwr_i,
    // Hub controller, receiver and neighbouring states
    input  wire        rx_suspend_i,
    input  wire        susp_chg_any_i,
    input  wire        port_chg_any_i,
    input  wire        hub_chg_any_i,
    input  wire        port_error_i,
    input  wire        restart_done_i,
    input  wire        hs_mode_i,
    // Port drivers and status
    output wire        drive_se0_o,
    output wire        diff_tx_en_o,
    output wire        diff_rx_en_o,
    output wire        se_tx_en_o,
    output wire        se_rx_en_o,
    output wire        hs_term_o,
    output wire        propagate_o,
    output wire        sop_emul_o,
    output wire        clk_wake_o,
    output wire        resume_event_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg  [5:0] pin_m_q;
    reg  [5:0] pin_s_q;
    reg        ext_prev_q;
    wire       dp_s     = pin_s_q[0];
    wire       dm_s     = pin_s_q[1];
    wire       fault_s  = pin_s_q[2];
    wire       oc_s     = pin_s_q[3];
    wire       oc_oth_s = pin_s_q[4];
    wire       ext_s    = pin_s_q[5];
    wire       se0_line = ~dp_s & ~dm_s;
    wire       se1_line = dp_s & dm_s;

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_m_q    <= 6'h00;
            pin_s_q    <= 6'h00;
            ext_prev_q <= 1'b0;
        end else begin
            pin_m_q    <= {ext_pwr_i, oc_other_i, oc_i, pwr_fault_i,
                           dm_i, dp_i};
            pin_s_q    <= pin_m_q;
            ext_prev_q <= ext_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone register access
    reg  [7:0]  cfg_q;
    reg         rwu_q;
    reg  [2:0]  chg_q;
    reg  [2:0]  pst_q;
    reg  [2:0]  pst_d;
    reg  [1:0]  ist_q;
    reg  [1:0]  ist_d;
    reg         hs_term_q;
    reg  [15:0] se0_len_q;
    wire        req   = cyc_i & stb_i;
    wire        wr_ok = req & we_i & ack_o;
    wire        cmd_wr = wr_ok & (adr_i == `REG_CMD) & sel_i[0];
    wire        clr_power  = cmd_wr & dat_i[`CMD_CLR_POWER];
    wire        set_power  = cmd_wr & dat_i[`CMD_SET_POWER];
    wire        clr_enable = cmd_wr & dat_i[`CMD_CLR_ENABLE];
    wire        set_enable = cmd_wr & dat_i[`CMD_SET_ENABLE];
    wire        cfg_wr = wr_ok & (adr_i == `REG_CTRL) & sel_i[0];
    wire        set_cfg_nz = cfg_wr & (dat_i[7:0] != 8'h00);
    wire        chg_wr = wr_ok & (adr_i == `REG_CHANGE) & sel_i[0];
    wire        conn_s = ~se0_line & ~se1_line;
    wire        hub_susp = (ist_q != `IST_INACTIVE);
    reg  [31:0] rd_d;

    always @* begin
        rd_d = 32'h0000_0000;
        case (adr_i)
            `REG_CTRL: begin
                rd_d[`CTRL_CFG_MSB:`CTRL_CFG_LSB] = cfg_q;
                rd_d[`CTRL_RWU_BIT] = rwu_q;
            end
            `REG_STATUS: begin
                rd_d[`STS_PST_LSB+2:`STS_PST_LSB] = pst_q;
                rd_d[`STS_IST_LSB+1:`STS_IST_LSB] = ist_q;
                rd_d[`STS_CONN_BIT] = conn_s;
                rd_d[`STS_HST_BIT]  = hs_term_q;
                rd_d[`STS_WAKE_BIT] = clk_wake_o;
                rd_d[`STS_SE0_LSB+15:`STS_SE0_LSB] = se0_len_q;
            end
            `REG_CHANGE: begin
                rd_d[2:0] = chg_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            cfg_q <= 8'h00;
            rwu_q <= 1'b0;
        end else begin
            ack_o <= req & ~ack_o;
            if (req & ~ack_o & ~we_i) begin
                dat_o <= rd_d;
            end
            if (cfg_wr) begin
                cfg_q <= dat_i[`CTRL_CFG_MSB:`CTRL_CFG_LSB];
            end
            if (wr_ok & (adr_i == `REG_CTRL) & sel_i[1]) begin
                rwu_q <= dat_i[`CTRL_RWU_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal port: suspend delay and resume generation
    reg  [`TMR_W-1:0] sdly_q;
    // RL3: resume condition
    wire resume_ev = susp_chg_any_i |
                     (rwu_q & (port_chg_any_i | hub_chg_any_i |
                               (chg_q != 3'h0)));

    always @* begin
        ist_d = ist_q;
        case (ist_q)
            `IST_INACTIVE: begin
                if (rx_suspend_i) begin
                    ist_d = `IST_SUSP_DLY;
                end
            end
            `IST_SUSP_DLY: begin
                // RL1: timed delay then full suspend
                if (sdly_q >= SUSP_DLY_CYC - 1'b1) begin
                    ist_d = `IST_FSUS;
                end
            end
            `IST_FSUS: begin
                // RL2: resume request leaves full suspend
                if (resume_ev) begin
                    ist_d = `IST_GRESUME;
                end
            end
            `IST_GRESUME: begin
                ist_d = `IST_GRESUME;
            end
            default: begin
                ist_d = `IST_INACTIVE;
            end
        endcase
        if (!rx_suspend_i) begin
            ist_d = `IST_INACTIVE;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ist_q  <= `IST_INACTIVE;
            sdly_q <= {`TMR_W{1'b0}};
        end else begin
            ist_q <= ist_d;
            if (ist_q == `IST_SUSP_DLY && ist_d == `IST_SUSP_DLY) begin
                sdly_q <= sdly_q + 1'b1;
            end else begin
                sdly_q <= {`TMR_W{1'b0}};
            end
        end
    end

    // RL4: start-of-packet emulation toward the repeater
    assign sop_emul_o     = (ist_q == `IST_GRESUME);
    assign resume_event_o = resume_ev;

    ////////////////////////////////////////////////////////////////////////
    // Line timers
    reg  [`TMR_W-1:0] line_q;
    reg  [`TMR_W-1:0] hold_q;
    localparam [`TMR_W-1:0] DDIS = `DDIS_CYC;
    // RL17: suspended hub without wakeup ignores a new connect
    wire conn_armed = ~hub_susp | rwu_q;
    // RL15: connect timer held in SE0/SE1, runs on other states
    wire conn_run   = (pst_q == `PST_DISCON) & conn_s & conn_armed;
    wire se0_run    = (pst_q != `PST_DISCON) & se0_line;
    wire line_run   = conn_run | se0_run;
    wire line_exp   = line_run & (line_q >= DDIS - 1'b1);
    // RL21: disconnect detection held off after Disabled entry
    wire hold_off   = (pst_q == `PST_DISABLED) &
                      (hold_q < DIS_HOLD_CYC - 1'b1);
    wire conn_exp   = conn_run & line_exp;
    wire disc_exp   = se0_run & line_exp & ~hold_off &
                      (pst_q != `PST_NOTCFG) & (pst_q != `PST_PWROFF);

    always @(posedge clk_i) begin
        if (rst_i) begin
            line_q    <= {`TMR_W{1'b0}};
            hold_q    <= {`TMR_W{1'b0}};
            se0_len_q <= 16'h0000;
        end else begin
            if (line_run && (pst_d == pst_q)) begin
                if (line_q != {`TMR_W{1'b1}}) begin
                    line_q <= line_q + 1'b1;
                end
            end else begin
                line_q <= {`TMR_W{1'b0}};
            end
            if (pst_q != `PST_DISABLED) begin
                hold_q <= {`TMR_W{1'b0}};
            end else if (hold_off) begin
                hold_q <= hold_q + 1'b1;
            end
            // RL20: every received SE0 is timed while Disabled
            if (pst_q == `PST_DISABLED && se0_line) begin
                se0_len_q <= ((line_q[`TMR_W-1:16] != 4'h0) ||
                              (&line_q[15:0])) ?
                             16'hffff : line_q[15:0] + 16'h0001;
            end
        end
    end

    // RL16: connect activity while suspended with wakeup wakes clocks
    assign clk_wake_o = hub_susp & rwu_q & (pst_q == `PST_DISCON) &
                        conn_s;

    ////////////////////////////////////////////////////////////////////////
    // Downstream port state machine
    // RL9: external power loss, whatever the power mode at configuration
    // RL10: bus-powered hub left unchanged when external power appears
    wire ext_lost = ext_prev_q & ~ext_s;
    // RL6: power clear, power fault or over-current
    // RL8: neighbour over-current that sags this supply
    wire pwr_off  = clr_power | fault_s | oc_s | oc_oth_s | ext_lost;

    always @* begin
        pst_d = pst_q;
        case (pst_q)
            `PST_NOTCFG: begin
                pst_d = `PST_PWROFF;
            end
            `PST_PWROFF: begin
                // RL12: power on to Disconnected
                if (set_power) begin
                    pst_d = `PST_DISCON;
                end
            end
            `PST_DISCON: begin
                // RL18: connection found
                if (conn_exp) begin
                    pst_d = `PST_DISABLED;
                end
            end
            `PST_DISABLED: begin
                if (set_enable) begin
                    pst_d = `PST_ENABLED;
                end
            end
            `PST_ENABLED: begin
                // RL19: port error or enable clear
                if (port_error_i | clr_enable) begin
                    pst_d = `PST_DISABLED;
                end
            end
            default: begin
                pst_d = `PST_PWROFF;
            end
        endcase
        // RL22: precedence order applied last-to-first
        // RL13: disconnect timer or restart end
        if ((disc_exp | restart_done_i) && pst_q != `PST_PWROFF &&
            pst_q != `PST_NOTCFG) begin
            pst_d = `PST_DISCON;
        end
        // RL6: power loss outside Not Configured
        if (pwr_off && pst_q != `PST_NOTCFG) begin
            pst_d = `PST_PWROFF;
        end
        // RL7: nonzero configuration accepted
        if (set_cfg_nz) begin
            pst_d = `PST_PWROFF;
        end
        // RL5: configuration zero
        if (cfg_q == 8'h00 && !set_cfg_nz) begin
            pst_d = `PST_NOTCFG;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pst_q     <= `PST_NOTCFG;
            hs_term_q <= 1'b0;
            chg_q     <= 3'h0;
        end else begin
            pst_q <= pst_d;
            // RL21: only Enabled keeps high-speed terminations
            hs_term_q <= (pst_d == `PST_ENABLED) & hs_mode_i;
            // Hardware set wins over software clear
            chg_q <= (chg_q & ~({3{chg_wr}} & dat_i[2:0])) |
                     {oc_s | oc_oth_s,
                      (pst_q == `PST_ENABLED) &
                      (pst_d == `PST_DISABLED),
                      conn_exp};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Port drivers
    wire st_nc  = (pst_q == `PST_NOTCFG);
    wire st_off = (pst_q == `PST_PWROFF);
    wire st_en  = (pst_q == `PST_ENABLED);

    // RL5: SE0 only while Not Configured, optional on a root hub
    assign drive_se0_o  = st_nc & (ROOT_SE0 != 0);
    assign se_tx_en_o   = st_nc & (ROOT_SE0 != 0);
    // RL11: Powered-off shuts all transmitters and receivers
    // RL14: Disconnected keeps only single-ended detection
    assign se_rx_en_o   = ~st_off & ~st_nc;
    // RL20: Disabled propagates nothing either way
    assign diff_tx_en_o = st_en;
    assign diff_rx_en_o = st_en;
    assign propagate_o  = st_en;
    assign hs_term_o    = hs_term_q;

endmodule // hub_port_fsm

// ==== bench/hub_port_chk.sv ====
`timescale 1ns/1ps
`include "hub_port_defs.vh"
module hub_port_chk #(
    parameter [`TMR_W-1:0] SUSP_DLY_CYC = 20'd20
) (
    // Clock, reset and bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [3:0]  sel_i,
    input wire [31:0] dat_i,
    input wire        ack_o,
    // Line and controller inputs
    input wire        dp_i,
    input wire        dm_i,
    input wire        oc_i,
    input wire        rx_suspend_i,
    input wire        susp_chg_any_i,
    // Port outputs
    input wire        drive_se0_o,
    input wire        diff_tx_en_o,
    input wire        diff_rx_en_o,
    input wire        se_tx_en_o,
    input wire        se_rx_en_o,
    input wire        propagate_o,
    input wire        sop_emul_o,
    input wire        clk_wake_o,
    input wire        resume_event_o
);
////////////////////////////////////////////////////////////////////////
logic [`TMR_W-1:0] sus_q;

// Consecutive cycles with the receiver suspended
always @(posedge clk_i) begin
    if (rst_i || !rx_suspend_i)
        sus_q <= '0;
    else if (sus_q != '1)
        sus_q <= sus_q + 1'b1;
end

default clocking @(posedge clk_i); endclocking
default disable iff (rst_i);

sequence s_ctrl_wr;
    cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == `REG_CTRL;
endsequence
////////////////////////////////////////////////////////////////////////
a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged");
a_cfg_zero: assert property (
    s_ctrl_wr ##0 dat_i[7:0] == 8'h00 |=> ##1 drive_se0_o)
    else $error("zero config not applied");
a_cfg_set: assert property (
    s_ctrl_wr ##0 dat_i[7:0] != 8'h00 |=> !se_rx_en_o && !drive_se0_o)
    else $error("config write did not power off");
a_notcfg_quiet: assert property (
    drive_se0_o |-> !diff_tx_en_o && !propagate_o && !se_rx_en_o)
    else $error("signaling while unconfigured");
a_pwroff_quiet: assert property (
    !drive_se0_o && !se_rx_en_o |-> !se_tx_en_o && !diff_tx_en_o
        && !diff_rx_en_o)
    else $error("driver enabled while powered off");
a_only_enabled: assert property (
    propagate_o |-> diff_tx_en_o && diff_rx_en_o && se_rx_en_o)
    else $error("propagation outside enabled");
a_oc_off: assert property (
    (oc_i && !drive_se0_o) [*4] |=> !se_rx_en_o)
    else $error("over-current did not power off");
a_resume_src: assert property (
    susp_chg_any_i |-> resume_event_o)
    else $error("suspend change gave no resume");
a_gres_entry: assert property (
    $rose(sop_emul_o) |-> $past(resume_event_o) && sus_q >= SUSP_DLY_CYC)
    else $error("resume emulation entered early");
a_sop_hold: assert property (
    sop_emul_o && rx_suspend_i |=> sop_emul_o)
    else $error("resume emulation dropped");
a_wake_line: assert property (
    clk_wake_o |-> $past(dp_i, 2) != $past(dm_i, 2) && se_rx_en_o)
    else $error("wake without line activity");
endmodule // hub_port_chk

// ==== bench/usb_dev_model.sv ====
`timescale 1ns/1ps
// Device idles J when attached; hub pull-downs give SE0 when absent
module usb_dev_model (
    // Clock and control
    input  wire  clk_i,
    input  wire  attach_i,
    input  wire  se0_i,
    // Bus lines
    output logic dp_o,
    output logic dm_o
);
always @(posedge clk_i) begin
    dp_o <= attach_i && !se0_i;
    dm_o <= 1'b0;
end
endmodule // usb_dev_model

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`include "hub_port_defs.vh"
module tb;
logic        clk_i, rst_i, cyc_i, stb_i, we_i, attach, se0;
logic [7:0]  adr_i;
logic [3:0]  sel_i;
logic [31:0] dat_i, rd;
wire  [31:0] dat_o;
wire         ack_o, dp_i, dm_i;
logic        pwr_fault_i, oc_i, oc_other_i, ext_pwr_i, rx_suspend_i;
logic        susp_chg_any_i, port_chg_any_i, hub_chg_any_i;
logic        port_error_i, restart_done_i, hs_mode_i;
wire         drive_se0_o, diff_tx_en_o, diff_rx_en_o, se_tx_en_o;
wire         se_rx_en_o, hs_term_o, propagate_o, sop_emul_o;
wire         clk_wake_o, resume_event_o;
int          bad_count, cmp_count, i;

hub_port_fsm #(.SUSP_DLY_CYC(20'd20), .DIS_HOLD_CYC(20'd400)) i_dut (.*);
usb_dev_model i_dev (.clk_i(clk_i), .attach_i(attach), .se0_i(se0),
                     .dp_o(dp_i), .dm_o(dm_i));
////////////////////////////////////////////////////////////////////////
task automatic wb(input [7:0] a, input [31:0] d, input [3:0] s,
                  input logic w);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    do begin
        @(posedge clk_i);
    end while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i, we_i} <= 3'h0;
endtask
task chk(input [31:0] g, input [31:0] e);
    cmp_count++;
    if (g !== e) begin
        bad_count++;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
endtask
task st(input [2:0] e);
    wb(`REG_STATUS, 32'h0, 4'hf, 1'b0);
    chk(rd[`STS_PST_LSB +: 3], e);
endtask
task ist(input [1:0] e);
    wb(`REG_STATUS, 32'h0, 4'hf, 1'b0);
    chk(rd[`STS_IST_LSB +: 2], e);
endtask
task stop_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
endtask
////////////////////////////////////////////////////////////////////////
initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
end
initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    stop_test;
end
initial begin
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= '0;
    {pwr_fault_i, oc_i, oc_other_i, rx_suspend_i, attach, se0} <= '0;
    {susp_chg_any_i, port_chg_any_i, hub_chg_any_i} <= '0;
    {port_error_i, restart_done_i, hs_mode_i} <= '0;
    ext_pwr_i <= 1'b1;
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    st(`PST_NOTCFG);
    chk(drive_se0_o, 1);
    wb(8'h40, 32'h0, 4'hf, 1'b0);
    chk(rd, 32'h0);
    oc_i <= 1'b1;
    st(`PST_NOTCFG);
    oc_i <= 1'b0;
    wb(`REG_CTRL, 32'h1, 4'h1, 1'b1);
    st(`PST_PWROFF);
    chk({se_rx_en_o, se_tx_en_o, diff_rx_en_o}, 0);
    wb(`REG_CMD, 32'h3, 4'h1, 1'b1);
    st(`PST_PWROFF);
    wb(`REG_CMD, 32'h2, 4'h1, 1'b1);
    st(`PST_DISCON);
    chk({diff_tx_en_o, diff_rx_en_o, se_rx_en_o}, 1);
    repeat (400) @(posedge clk_i);
    st(`PST_DISCON);
    attach <= 1'b1;
    repeat (300) @(posedge clk_i);
    st(`PST_DISCON);
    repeat (20) @(posedge clk_i);
    st(`PST_DISABLED);
    chk({diff_tx_en_o, propagate_o}, 0);
    wb(`REG_CHANGE, 32'h0, 4'hf, 1'b0);
    chk(rd[`CHG_CONN_BIT], 1);
    se0 <= 1'b1;
    repeat (50) @(posedge clk_i);
    se0 <= 1'b0;
    repeat (4) @(posedge clk_i);
    st(`PST_DISABLED);
    chk(rd[31:16], 32'd50);
    wb(`REG_CMD, 32'h8, 4'h1, 1'b1);
    port_error_i <= 1'b1;
    @(posedge clk_i);
    port_error_i <= 1'b0;
    st(`PST_DISABLED);
    wb(`REG_CHANGE, 32'h0, 4'hf, 1'b0);
    chk(rd[`CHG_ENA_BIT], 1);
    hs_mode_i <= 1'b1;
    wb(`REG_CMD, 32'h8, 4'h1, 1'b1);
    st(`PST_ENABLED);
    chk({hs_term_o, propagate_o}, 3);
    restart_done_i <= 1'b1;
    @(posedge clk_i);
    restart_done_i <= 1'b0;
    st(`PST_DISCON);
    repeat (320) @(posedge clk_i);
    st(`PST_DISABLED);
    wb(`REG_CMD, 32'h8, 4'h1, 1'b1);
    st(`PST_ENABLED);
    wb(`REG_CMD, 32'h4, 4'h1, 1'b1);
    se0 <= 1'b1;
    st(`PST_DISABLED);
    chk(hs_term_o, 0);
    repeat (370) @(posedge clk_i);
    st(`PST_DISABLED);
    repeat (380) @(posedge clk_i);
    st(`PST_DISCON);
    {se0, attach} <= 2'b00;
    for (i = 0; i < 5; i++) begin
        wb(`REG_CMD, 32'h2, 4'h1, 1'b1);
        st(`PST_DISCON);
        case (i)
            0: wb(`REG_CMD, 32'h1, 4'h1, 1'b1);
            1: pwr_fault_i <= 1'b1;
            2: oc_i <= 1'b1;
            3: oc_other_i <= 1'b1;
            default: ext_pwr_i <= 1'b0;
        endcase
        repeat (4) @(posedge clk_i);
        st(`PST_PWROFF);
        {pwr_fault_i, oc_i, oc_other_i, ext_pwr_i} <= 4'h1;
        wb(`REG_CMD, 32'h2, 4'h1, 1'b1);
        st(`PST_DISCON);
    end
    wb(`REG_CMD, 32'h2, 4'h1, 1'b1);
    wb(`REG_CHANGE, 32'h7, 4'h1, 1'b1);
    rx_suspend_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    ist(`IST_SUSP_DLY);
    repeat (20) @(posedge clk_i);
    ist(`IST_FSUS);
    {attach, port_chg_any_i} <= 2'b11;
    repeat (5) @(posedge clk_i);
    chk({clk_wake_o, resume_event_o}, 0);
    wb(`REG_CTRL, 32'h100, 4'h2, 1'b1);
    ist(`IST_GRESUME);
    chk({sop_emul_o, clk_wake_o}, 3);
    for (i = 0; i < 2; i++) begin
        {rx_suspend_i, port_chg_any_i} <= 2'b00;
        {susp_chg_any_i, hub_chg_any_i} <= 2'b00;
        repeat (3) @(posedge clk_i);
        ist(`IST_INACTIVE);
        rx_suspend_i <= 1'b1;
        repeat (30) @(posedge clk_i);
        {susp_chg_any_i, hub_chg_any_i} <= (i == 0) ? 2'b10 : 2'b01;
        ist(`IST_GRESUME);
    end
    oc_i <= 1'b1;
    wb(`REG_CTRL, 32'h0, 4'h3, 1'b1);
    st(`PST_NOTCFG);
    stop_test;
end
endmodule // tb

bind hub_port_fsm hub_port_chk #(.SUSP_DLY_CYC(SUSP_DLY_CYC)) i_chk (.*);
